/* File: rtl/modem_sync.v */
`timescale 1ns/1ps
// ****************************************
// two-stage synchroniser for modem inputs
// ****************************************
module modem_sync (
  input  wire       i_core_clk,
  input  wire       i_resetn,
  input  wire [2:0] i_async,
  output wire [2:0] o_sync
);

  reg [2:0] stage1_reg;
  reg [2:0] stage2_reg;

  // idle level of the active-low pins is high
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1_reg <= 3'h7;
      stage2_reg <= 3'h7;
    end else begin
      stage1_reg <= i_async; // RULE12
      stage2_reg <= stage1_reg; // RULE12
    end
  end

  assign o_sync = stage2_reg;

endmodule

/* File: rtl/uart_modem_consts.vh */
`ifndef UART_MODEM_CONSTS_VH
`define UART_MODEM_CONSTS_VH

// register indices on the three host address lines
`define IDX_BUS_MODE    3'h1
`define IDX_MODEM_CTRL  3'h4
`define IDX_MODEM_STAT  3'h6
`define IDX_SCRATCH     3'h7

// modem control fields
`define MCR_DTR_BIT     0
`define MCR_RESET       8'h00

// modem status fields
`define MSR_DCTS_BIT    0
`define MSR_DDSR_BIT    1
`define MSR_DDCD_BIT    3
`define MSR_CTS_BIT     4
`define MSR_DSR_BIT     5
`define MSR_CD_BIT      7

// bus mode status field
`define BMS_MODE16_BIT  0

`define SCRATCH_RESET   8'h00
`define MODE16_RESET    1'b1

// axi4-lite slave
`define AXI_ADDR_W      8
`define AXI_IDX_LSB     2
`define AXI_IDX_MSB     4
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* File: rtl/uart_modem_pins_bus_select.v */
`timescale 1ns/1ps
// Overview of operation
// RULE1: strap high or floating selects 16 mode strobes; pull-up lies outside.
// RULE2: strap low selects 68 mode: chip select strobe plus read/write line.
// RULE3: three address lines pick the internal register accessed.
// RULE4: accesses are honoured only while active-low chip select is low; axi4-lite accesses are honoured whatever chip select is.
// RULE5: carrier detect input low reads as modem status bit 7 set.
// RULE6: clear-to-send input low reads as modem status bit 4 set.
// RULE7: data-set-ready input low reads as modem status bit 5 set.
// RULE8: writing one to modem control bit 0 drives terminal-ready output low.
// RULE9: writing zero there, or any reset, drives terminal-ready output high.
// RULE10: host data is eight bits, bit 0 least significant, three-state.
// RULE11: each modem status bit is the complement of its synchronised pin.
// RULE12: modem inputs pass two flip-flop stages before reaching status.
`include "uart_modem_consts.vh"

module uart_modem_pins_bus_select (
  input  wire                   i_core_clk,
  input  wire                   i_resetn,
  // parallel host bus
  input  wire                   i_bus_sel,
  input  wire                   i_cs_n,
  input  wire                   i_reg_addr_bit_low,
  input  wire                   i_reg_addr_bit_mid,
  input  wire                   i_reg_addr_bit_high,
  input  wire                   i_rd_n,
  input  wire                   i_wr_n,
  input  wire                   i_rw,
  input  wire [7:0]             i_data,
  output reg  [7:0]             o_data,
  output reg                    o_data_oe,
  // modem pins
  input  wire                   i_cts_n,
  input  wire                   i_dsr_n,
  input  wire                   i_carrier_detect_input_n,
  output reg                    o_dtr_n,
  // axi4-lite slave
  input  wire                   i_axi_awvalid,
  output reg                    o_axi_awready,
  input  wire [`AXI_ADDR_W-1:0] i_axi_awaddr,
  input  wire                   i_axi_wvalid,
  output reg                    o_axi_wready,
  input  wire [31:0]            i_axi_wdata,
  input  wire [3:0]             i_axi_wstrb,
  output reg                    o_axi_bvalid,
  input  wire                   i_axi_bready,
  output reg  [1:0]             o_axi_bresp,
  input  wire                   i_axi_arvalid,
  output reg                    o_axi_arready,
  input  wire [`AXI_ADDR_W-1:0] i_axi_araddr,
  output reg                    o_axi_rvalid,
  input  wire                   i_axi_rready,
  output reg  [31:0]            o_axi_rdata,
  output reg  [1:0]             o_axi_rresp
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_WRITE = 3'b100;

  // ****************************************
  // state
  // ****************************************
  reg       mode16_reg;
  reg       strap_done_reg;
  reg [7:0] mcr_reg;
  reg [7:0] mcr_next;
  reg [7:0] scratch_reg;
  reg [7:0] scratch_next;
  reg [2:0] delta_reg;
  reg [2:0] delta_next;
  reg [2:0] status_prev_reg;
  reg [2:0] par_state_reg;
  reg [2:0] par_state_next;

  reg                    aw_held_reg;
  reg [`AXI_ADDR_W-1:0]  aw_addr_reg;
  reg                    w_held_reg;
  reg [7:0]              w_data_reg;
  reg                    w_strb_reg;

  wire [2:0] pins_sync;
  wire [2:0] status_now;
  wire [2:0] par_idx;
  wire       rd_req;
  wire       wr_req;
  wire       par_rd_take;
  wire       par_wr_take;
  wire       axi_wr_fire;
  wire       axi_rd_fire;
  wire       axi_wr_ok;
  wire       axi_rd_ok;
  wire [2:0] axi_wr_idx;
  wire [2:0] axi_rd_idx;
  wire       msr_read;

  // ****************************************
  // helpers
  // ****************************************
  function addr_mapped;
    input [`AXI_ADDR_W-1:0] addr;
    begin
      addr_mapped = (addr[`AXI_ADDR_W-1:`AXI_IDX_MSB+1] == 3'h0) &&
                    (addr[`AXI_IDX_LSB-1:0] == 2'h0);
    end
  endfunction

  function [7:0] read_reg;
    input [2:0] idx;
    input       mode16;
    input [7:0] modem_control_register;
    input [7:0] scratch;
    input [2:0] delta;
    input [2:0] status;
    reg   [7:0] v;
    begin
      v = 8'h00;
      case (idx)
        `IDX_BUS_MODE: begin
          v[`BMS_MODE16_BIT] = mode16;
        end
        `IDX_MODEM_CTRL: begin
          v = modem_control_register;
        end
        `IDX_MODEM_STAT: begin
          v[`MSR_DCTS_BIT] = delta[0];
          v[`MSR_DDSR_BIT] = delta[1];
          v[`MSR_DDCD_BIT] = delta[2];
          v[`MSR_CTS_BIT] = status[0]; // RULE6
          v[`MSR_DSR_BIT] = status[1]; // RULE7
          v[`MSR_CD_BIT] = status[2]; // RULE5
        end
        `IDX_SCRATCH: begin
          v = scratch;
        end
        default: begin
          v = 8'h00;
        end
      endcase
      read_reg = v;
    end
  endfunction

  // ****************************************
  // modem inputs
  // ****************************************
  modem_sync u_modem_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    ({i_carrier_detect_input_n, i_dsr_n, i_cts_n}),
    .o_sync     (pins_sync)
  );

  assign status_now = ~pins_sync; // RULE11

  // ****************************************
  // bus style strap
  // ****************************************
  // sampled once after reset release so a glitch later cannot flip the protocol
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode16_reg <= `MODE16_RESET;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      mode16_reg <= i_bus_sel; // RULE1 RULE2
      strap_done_reg <= 1'b1;
    end
  end

  // ****************************************
  // parallel host bus
  // ****************************************
  assign par_idx = {i_reg_addr_bit_high, i_reg_addr_bit_mid, i_reg_addr_bit_low}; // RULE3

  assign rd_req = !i_cs_n && (mode16_reg ? !i_rd_n : i_rw); // RULE4 RULE1 RULE2
  assign wr_req = !i_cs_n && (mode16_reg ? !i_wr_n : !i_rw); // RULE4 RULE1 RULE2

  assign par_rd_take = strap_done_reg && (par_state_reg == ST_IDLE) && rd_req;
  assign par_wr_take = strap_done_reg && (par_state_reg == ST_IDLE) && !rd_req && wr_req;

  always @* begin
    par_state_next = par_state_reg;
    case (par_state_reg)
      ST_IDLE: begin
        if (par_rd_take) begin
          par_state_next = ST_READ;
        end else if (par_wr_take) begin
          par_state_next = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_req) begin
          par_state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_req) begin
          par_state_next = ST_IDLE;
        end
      end
      default: begin
        par_state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      par_state_reg <= ST_IDLE;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      par_state_reg <= par_state_next;
      o_data_oe <= (par_state_next == ST_READ); // RULE10
      if (par_rd_take) begin
        o_data <= read_reg(par_idx, mode16_reg, mcr_reg, scratch_reg, delta_reg, status_now); // RULE3 RULE10
      end
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign axi_wr_fire = aw_held_reg && w_held_reg && !o_axi_bvalid;
  assign axi_rd_fire = i_axi_arvalid && o_axi_arready;
  assign axi_wr_ok = addr_mapped(aw_addr_reg);
  assign axi_rd_ok = addr_mapped(i_axi_araddr);
  assign axi_wr_idx = aw_addr_reg[`AXI_IDX_MSB:`AXI_IDX_LSB];
  assign axi_rd_idx = i_axi_araddr[`AXI_IDX_MSB:`AXI_IDX_LSB];

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {`AXI_ADDR_W{1'b0}};
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      o_axi_awready <= 1'b0;
      o_axi_wready <= 1'b0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= `AXI_RESP_OKAY;
      o_axi_arready <= 1'b0;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= `AXI_RESP_OKAY;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_axi_awaddr;
        o_axi_awready <= 1'b0;
      end else if (axi_wr_fire) begin
        aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !o_axi_bvalid) begin
        o_axi_awready <= 1'b1;
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_axi_wdata[7:0];
        w_strb_reg <= i_axi_wstrb[0];
        o_axi_wready <= 1'b0;
      end else if (axi_wr_fire) begin
        w_held_reg <= 1'b0;
      end else if (!w_held_reg && !o_axi_bvalid) begin
        o_axi_wready <= 1'b1;
      end
      if (axi_wr_fire) begin
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= axi_wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
      if (axi_rd_fire) begin
        o_axi_arready <= 1'b0;
        o_axi_rvalid <= 1'b1;
        o_axi_rresp <= axi_rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        o_axi_rdata <= {24'h00_0000, axi_rd_ok ?
          read_reg(axi_rd_idx, mode16_reg, mcr_reg, scratch_reg, delta_reg, status_now) : 8'h00};
      end else if (o_axi_rvalid && i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
        o_axi_arready <= 1'b1;
      end else if (!o_axi_rvalid) begin
        o_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // register file
  // ****************************************
  assign msr_read = (par_rd_take && (par_idx == `IDX_MODEM_STAT)) ||
                    (axi_rd_fire && axi_rd_ok && (axi_rd_idx == `IDX_MODEM_STAT));

  // the axi write is applied last, so it wins a same-cycle clash on one register
  always @* begin
    mcr_next = mcr_reg;
    scratch_next = scratch_reg;
    if (par_wr_take) begin
      case (par_idx)
        `IDX_MODEM_CTRL: mcr_next = i_data; // RULE3 RULE8 RULE9
        `IDX_SCRATCH: scratch_next = i_data;
        default: begin
        end
      endcase
    end
    if (axi_wr_fire && axi_wr_ok && w_strb_reg) begin
      case (axi_wr_idx)
        `IDX_MODEM_CTRL: mcr_next = w_data_reg; // RULE8 RULE9
        `IDX_SCRATCH: scratch_next = w_data_reg;
        default: begin
        end
      endcase
    end
  end

  // delta flags: a change in the read cycle survives the clear
  always @* begin
    delta_next = msr_read ? 3'h0 : delta_reg;
    delta_next = delta_next | (status_now ^ status_prev_reg);
  end

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mcr_reg <= `MCR_RESET;
      scratch_reg <= `SCRATCH_RESET;
      delta_reg <= 3'h0;
      status_prev_reg <= 3'h0;
      o_dtr_n <= 1'b1; // RULE9
    end else begin
      mcr_reg <= mcr_next;
      scratch_reg <= scratch_next;
      delta_reg <= delta_next;
      status_prev_reg <= status_now;
      o_dtr_n <= ~mcr_next[`MCR_DTR_BIT]; // RULE8 RULE9
    end
  end

endmodule

/* File: sim/modem_model.sv */
`timescale 1ns/1ps
// ****
// modem end of the handshake pins
// ****
module modem_model (
  input  wire logic       i_core_clk,
  input  wire logic [2:0] i_state,
  input  wire logic       i_dtr_n,
  output logic            o_cts_n,
  output logic            o_dsr_n,
  output logic            o_cd_n,
  output logic            o_host_ready
);
  initial {o_cd_n, o_dsr_n, o_cts_n} = 3'h7;
  // pins follow the requested state one edge later, like a clocked far end
  always @(posedge i_core_clk) {o_cd_n, o_dsr_n, o_cts_n} <= ~i_state;
  always @(posedge i_core_clk) o_host_ready <= !i_dtr_n;
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "uart_modem_consts.vh"
module tb_top;
  // ****
  // harness
  // ****
  logic        i_core_clk = 1'b0, i_resetn = 1'b0, i_bus_sel = 1'b1, i_cs_n = 1'b1;
  logic        i_rd_n = 1'b1, i_wr_n = 1'b1, i_rw = 1'b1, i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0;
  logic        i_axi_bready = 1'b0, i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
  logic        i_reg_addr_bit_low = 1'b0, i_reg_addr_bit_mid = 1'b0, i_reg_addr_bit_high = 1'b0;
  logic [7:0]  i_data = 8'h00, i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00, o_data, q;
  logic [31:0] i_axi_wdata = 32'h0, o_axi_rdata;
  logic [3:0]  i_axi_wstrb = 4'hf;
  logic [2:0]  mstate = 3'h0;
  logic [1:0]  o_axi_bresp, o_axi_rresp;
  logic        o_data_oe, o_dtr_n, o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic        i_cts_n, i_dsr_n, i_carrier_detect_input_n, host_ready;
  int          mismatches = 0, checks_done = 0, i;
  initial forever #5 i_core_clk = ~i_core_clk;
  uart_modem_pins_bus_select dut (.*);
  modem_model modem (.i_core_clk, .i_state(mstate), .i_dtr_n(o_dtr_n), .o_cts_n(i_cts_n),
    .o_dsr_n(i_dsr_n), .o_cd_n(i_carrier_detect_input_n), .o_host_ready(host_ready));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rst(input logic mode);
    i_resetn <= 1'b0;
    i_bus_sel <= mode;
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
  endtask
  // one parallel access; q keeps 8'hee when nothing drives the bus
  task automatic par(input logic wr, input logic cs, input logic [2:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_cs_n <= cs;
    {i_reg_addr_bit_high, i_reg_addr_bit_mid, i_reg_addr_bit_low} <= a;
    i_data <= d;
    i_rd_n <= wr;
    i_wr_n <= !wr;
    i_rw <= !wr;
    q = 8'hee;
    for (int n = 0; n < 8 && !wr && q === 8'hee; n++) begin
      @(posedge i_core_clk);
      if (o_data_oe === 1'b1)
        q = o_data;
    end
    if (wr)
      @(posedge i_core_clk);
    i_cs_n <= 1'b1;
    i_rd_n <= 1'b1;
    i_wr_n <= 1'b1;
    i_rw <= 1'b1;
    // idle gap so the next access is seen as new
    repeat (2) @(posedge i_core_clk);
  endtask
  task automatic aw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge i_core_clk);
    i_axi_awvalid <= 1'b1;
    i_axi_awaddr <= a;
    i_axi_wvalid <= 1'b1;
    i_axi_wdata <= d;
    i_axi_bready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (o_axi_awready === 1'b1)
        i_axi_awvalid <= 1'b0;
      if (o_axi_wready === 1'b1)
        i_axi_wvalid <= 1'b0;
    end while (o_axi_bvalid !== 1'b1);
    i_axi_bready <= 1'b0;
    chk(o_axi_bresp, r, "bresp");
  endtask
  task automatic ar(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge i_core_clk);
    i_axi_arvalid <= 1'b1;
    i_axi_araddr <= a;
    i_axi_rready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (o_axi_arready === 1'b1)
        i_axi_arvalid <= 1'b0;
    end while (o_axi_rvalid !== 1'b1);
    i_axi_rready <= 1'b0;
    chk(o_axi_rdata, e, "rdata");
    chk(o_axi_rresp, r, "rresp");
  endtask
  initial begin
    repeat (5000) @(posedge i_core_clk);
    mismatches++;
    $display("unexpected timeout: expected end seen hang");
    end_sim();
  end
  // ****
  // tests
  // ****
  initial begin
    rst(1'b1);
    chk(o_dtr_n, 1'b1, "dtr_n");
    ar(8'h04, 32'h1, `AXI_RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      mstate <= i[2:0];
      repeat (6) @(posedge i_core_clk);
      par(1'b0, 1'b0, `IDX_MODEM_STAT, 8'h00);
      chk(q & 8'hb0, {i[2], 1'b0, i[1:0], 4'h0}, "status");
    end
    par(1'b1, 1'b0, `IDX_MODEM_CTRL, 8'h01);
    chk(o_dtr_n, 1'b0, "dtr_n");
    chk(host_ready, 1'b1, "modem ready");
    par(1'b1, 1'b1, `IDX_MODEM_CTRL, 8'h00);
    chk(o_dtr_n, 1'b0, "dtr_n");
    par(1'b0, 1'b1, `IDX_MODEM_CTRL, 8'h00);
    chk(q, 8'hee, "deselected read");
    par(1'b1, 1'b0, `IDX_MODEM_CTRL, 8'h00);
    chk(o_dtr_n, 1'b1, "dtr_n");
    aw(8'h10, 32'h1, `AXI_RESP_OKAY);
    chk(o_dtr_n, 1'b0, "dtr_n");
    par(1'b1, 1'b0, `IDX_SCRATCH, 8'h5a);
    for (i = 0; i < 8; i++)
      if (i != `IDX_MODEM_STAT)
        ar({3'h0, i[2:0], 2'h0}, (i == `IDX_BUS_MODE || i == `IDX_MODEM_CTRL) ? 32'h1 :
          (i == `IDX_SCRATCH) ? 32'h5a : 32'h0, `AXI_RESP_OKAY);
    aw(8'hf0, 32'h0, `AXI_RESP_SLVERR);
    chk(o_dtr_n, 1'b0, "dtr_n");
    ar(8'h1e, 32'h0, `AXI_RESP_SLVERR);
    rst(1'b0);
    chk(o_dtr_n, 1'b1, "dtr_n");
    ar(8'h04, 32'h0, `AXI_RESP_OKAY);
    par(1'b1, 1'b0, `IDX_MODEM_CTRL, 8'h01);
    chk(o_dtr_n, 1'b0, "dtr_n");
    par(1'b0, 1'b0, `IDX_MODEM_CTRL, 8'h00);
    chk(q, 8'h01, "ctrl read");
    end_sim();
  end
endmodule

/* File: sim/uart_modem_sva.sv */
`timescale 1ns/1ps
`include "uart_modem_consts.vh"
// ****
// parallel bus and modem pin checks
// ****
module uart_modem_sva (
  input wire       i_core_clk,
  input wire       i_resetn,
  input wire       i_bus_sel,
  input wire       i_cs_n,
  input wire       i_reg_addr_bit_low,
  input wire       i_reg_addr_bit_mid,
  input wire       i_reg_addr_bit_high,
  input wire       i_rd_n,
  input wire       i_wr_n,
  input wire       i_rw,
  input wire [7:0] i_data,
  input wire [7:0] o_data,
  input wire       o_data_oe,
  input wire       i_cts_n,
  input wire       i_dsr_n,
  input wire       i_carrier_detect_input_n,
  input wire       o_dtr_n,
  input wire       o_axi_bvalid
);
  wire [2:0] idx  = {i_reg_addr_bit_high, i_reg_addr_bit_mid, i_reg_addr_bit_low};
  wire [2:0] pins = {i_carrier_detect_input_n, i_dsr_n, i_cts_n};
  wire       rreq = !i_cs_n && (i_bus_sel ? !i_rd_n : i_rw);
  wire       wreq = !i_cs_n && (i_bus_sel ? (!i_wr_n && i_rd_n) : !i_rw);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  a_dtr_after_reset: assert property ($rose(i_resetn) |-> o_dtr_n)
    else $error("terminal ready active after reset");
  a_ctrl_write_dtr: assert property (wreq && idx == `IDX_MODEM_CTRL |=> o_dtr_n == !$past(i_data[0]))
    else $error("terminal ready does not follow control write");
  a_mode16_read: assert property (i_bus_sel && !i_cs_n && !i_rd_n && $past(i_cs_n) |=> o_data_oe)
    else $error("strobe read not answered");
  a_mode68_read: assert property (!i_bus_sel && !i_cs_n && i_rw && $past(i_cs_n) |=> o_data_oe)
    else $error("direction read not answered");
  a_no_stray_drive: assert property (!o_data_oe && !rreq |=> !o_data_oe)
    else $error("data bus driven without selected read");
  a_drive_release: assert property (o_data_oe && !rreq |=> !o_data_oe)
    else $error("data bus not released");
  // two sync stages plus the capturing edge: status reflects pins three edges back
  a_status_bits: assert property ($rose(o_data_oe) && $past(idx) == `IDX_MODEM_STAT |->
    {o_data[7], o_data[5], o_data[4]} == ~$past(pins, 3))
    else $error("modem status bits wrong");
  // only a register bus write, seen as bvalid rising, may move it while deselected
  a_dtr_hold: assert property (!wreq && i_cs_n |=> $stable(o_dtr_n) || $rose(o_axi_bvalid))
    else $error("terminal ready moved while deselected");
endmodule
bind uart_modem_pins_bus_select uart_modem_sva chk_i (.*);
